//--- src/tbq_qualifier.v
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "tbq_defines.vh"
module tbq_qualifier (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        cyc_valid,
  input  wire        cyc_exec,
  input  wire [15:0] exec_sel,
  input  wire [15:0] exec_off,
  input  wire [19:0] bus_addr,
  input  wire [15:0] bus_data,
  input  wire        bus_write,
  input  wire [1:0]  bus_space,
  input  wire        coproc_cycle,
  input  wire        sys_break_in,
  input  wire [7:0]  clips,
  output wire        halt,
  output wire        irq
);
  // Event machine states, one-hot
  localparam [3:0] ST0 = 4'b0001;
  localparam [3:0] ST1 = 4'b0010;
  localparam [3:0] ST2 = 4'b0100;
  localparam [3:0] ST3 = 4'b1000;

  reg  [6:0]  ctrl_q;
  reg  [3:0]  brk_en_q;
  reg  [19:0] brk_addr_q [0:3];
  reg  [19:0] arm_lo_q;
  reg  [19:0] arm_hi_q;
  reg  [6:0]  sys_ctrl_q;
  reg  [19:0] sys_addr_q;
  reg  [15:0] sys_data_q;
  reg  [15:0] clip_q;
  reg  [19:0] trq_start_q;
  reg  [19:0] trq_end_q;
  reg  [27:0] evm_prog_q [0:1];
  reg  [15:0] tick_q;
  reg  [4:0]  irq_stat_q;
  reg  [4:0]  irq_en_q;
  reg  [9:0]  trc_idx_q;
  reg         halt_q;
  reg         window_q;
  reg         trace_on_q;
  reg         check_pend_q;
  reg  [3:0]  evm_q [0:1];
  reg  [3:0]  evm_d [0:1];
  reg  [1:0]  evm_brk;
  reg  [6:0]  acc_q;
  reg  [15:0] unit_q;
  reg  [10:0] tt_q;
  reg  [10:0] tt_base_q;
  reg         rd_lo_q;
  reg  [7:0]  rd_addr_q;
  reg  [2:0]  acc_code;
  reg  [47:0] frame;

  wire        step;
  wire [19:0] exec_phys;
  wire        is_exec;
  wire        is_bus;
  wire [3:0]  brk_hit;
  wire        exec_brk;
  wire        in_arm;
  wire        sys_match;
  wire        sys_brk;
  wire        evm_break;
  wire        any_brk;
  wire        store;
  wire        clr_trace;
  wire [47:0] rd_frame;
  wire [9:0]  trc_cnt;
  wire        trc_full;
  wire        unit_tick;
  wire [6:0]  acc_sum;
  wire [15:0] tick_per;
  wire        wr_resume;
  wire        wr_check;
  wire [4:0]  irq_set;

  // Sampled once per observed cycle, frozen while halted
  assign step    = cyc_valid & ~halt_q;
  assign is_exec = step & cyc_exec;
  assign is_bus  = step & ~cyc_exec;
  // Physical address from selector and offset
  assign exec_phys = {exec_sel, 4'h0} + {4'h0, exec_off};

  // Execution break comparators, any subset may be live
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_brk
      assign brk_hit[gi] = brk_en_q[gi] & (exec_phys == brk_addr_q[gi]);
    end
  endgenerate
  assign exec_brk = is_exec & ctrl_q[`TBQ_C_BRK] & (|brk_hit);

  // Arm range on execution addresses
  assign in_arm = (exec_phys >= arm_lo_q) & (exec_phys <= arm_hi_q);

  // System condition: enabled address, data, clip and direction qualifiers must all agree; break line and coprocessor cycle match alone
  assign sys_match = (is_bus
    & (~sys_ctrl_q[`TBQ_S_ADDR] | (bus_addr == sys_addr_q))
    & (~sys_ctrl_q[`TBQ_S_DATA] | (bus_data == sys_data_q))
    & (~sys_ctrl_q[`TBQ_S_CLIP] | (((clips ^ clip_q[7:0]) & clip_q[15:8])
                                    == 8'h00))
    & (~sys_ctrl_q[`TBQ_S_RDONLY] | ~bus_write)
    & (~sys_ctrl_q[`TBQ_S_WRONLY] | bus_write)
    & (|sys_ctrl_q[2:0]))
    | (step & sys_ctrl_q[`TBQ_S_SYSBRK] & sys_break_in)
    | (is_bus & sys_ctrl_q[`TBQ_S_COPROC] & coproc_cycle);

  // Armed mode gates the trigger by the window; plain mode breaks directly
  assign sys_brk = sys_match & (ctrl_q[`TBQ_C_ARM] ? window_q
                                : ctrl_q[`TBQ_C_SYS]);

  // Break window: arm on entry to range, disarm on execution outside
  always @(posedge mclk) begin
    if (rst)
      window_q <= 1'b0;
    else if (is_exec && ctrl_q[`TBQ_C_ARM])
      window_q <= in_arm;
  end

  // Event machines, machine 0 watches bus, machine 1 execution
  genvar gm;
  generate
    for (gm = 0; gm < 2; gm = gm + 1) begin : g_evm
      reg [6:0] prog;
      reg       cond;
      wire      cross_machine_link;
      // Top state of the other machine is the cross-link
      assign cross_machine_link = evm_q[1-gm][3];
      always @* begin
        case (evm_q[gm])
          ST0:     prog = evm_prog_q[gm][6:0];
          ST1:     prog = evm_prog_q[gm][13:7];
          ST2:     prog = evm_prog_q[gm][20:14];
          ST3:     prog = evm_prog_q[gm][27:21];
          default: prog = evm_prog_q[gm][6:0];
        endcase
        case (prog[1:0])
          `TBQ_EC_ALWAYS: cond = 1'b1;
          `TBQ_EC_EXEC:   cond = cyc_exec & in_arm;
          `TBQ_EC_SYS:    cond = sys_match;
          `TBQ_EC_CROSS_MACHINE_LINK:  cond = cross_machine_link;
          default:        cond = 1'b0;
        endcase
        evm_d[gm] = evm_q[gm];
        evm_brk[gm] = 1'b0;
        if (step && ctrl_q[`TBQ_C_EVM]) begin
          if (cond && prog[2])
            evm_brk[gm] = 1'b1;
          else if (cond)
            evm_d[gm] = 4'b0001 << prog[4:3];
          else
            evm_d[gm] = 4'b0001 << prog[6:5];
        end
      end
      always @(posedge mclk) begin
        if (rst || !ctrl_q[`TBQ_C_EVM])
          evm_q[gm] <= ST0;
        else
          evm_q[gm] <= evm_d[gm];
      end
    end
  endgenerate
  assign evm_break = |evm_brk;

  assign any_brk   = exec_brk | sys_brk | evm_break;
  assign wr_resume = reg_wr && (reg_addr == `TBQ_RESUME);
  assign wr_check  = reg_wr && (reg_addr == `TBQ_CHECK);

  // Halt and check handshake; a break beats a check or resume write in the same cycle
  always @(posedge mclk) begin
    if (rst) begin
      halt_q       <= 1'b0;
      check_pend_q <= 1'b0;
    end else if (any_brk) begin
      halt_q       <= 1'b1;
      check_pend_q <= ctrl_q[`TBQ_C_CHECK];
    end else if (wr_check && check_pend_q) begin
      check_pend_q <= 1'b0;
      halt_q       <= reg_wdata[0];
    end else if (wr_resume) begin
      halt_q       <= 1'b0;
      check_pend_q <= 1'b0;
    end
  end
  assign halt = halt_q;

  // Trace qualification range
  always @(posedge mclk) begin
    if (rst)
      trace_on_q <= 1'b0;
    else if (is_exec && exec_phys == trq_start_q)
      trace_on_q <= 1'b1;
    else if (is_exec && exec_phys == trq_end_q)
      trace_on_q <= 1'b0;
  end

  // 100 ns unit from a phase accumulator, since 100 ns is 12.5 clocks
  assign acc_sum   = acc_q + `TBQ_CLK_NS;
  assign unit_tick = (acc_sum >= `TBQ_UNIT_NS);
  assign tick_per  = (tick_q == 16'h0000) ? 16'h0001 : tick_q;
  always @(posedge mclk) begin
    if (rst) begin
      acc_q  <= 7'h00;
      unit_q <= 16'h0000;
      tt_q   <= 11'h000;
    end else begin
      acc_q <= unit_tick ? acc_sum - `TBQ_UNIT_NS : acc_sum;
      if (unit_tick) begin
        if (unit_q + 16'h0001 >= tick_per) begin
          unit_q <= 16'h0000;
          tt_q   <= tt_q + 11'h001;
        end else begin
          unit_q <= unit_q + 16'h0001;
        end
      end
    end
  end

  // Access code from cycle space and direction
  always @* begin
    case ({bus_space, bus_write})
      3'b000:  acc_code = `TBQ_AC_CODE_FETCH;
      3'b010:  acc_code = `TBQ_AC_DATA_READ;
      3'b011:  acc_code = `TBQ_AC_DATA_WRITE;
      3'b100:  acc_code = `TBQ_AC_IO_READ;
      3'b101:  acc_code = `TBQ_AC_IO_WRITE;
      default: acc_code = `TBQ_AC_OTHER;
    endcase
  end

  // Frame layout: tag, code, address, then data and clips, or timetag and zero fill
  always @* begin
    if (cyc_exec)
      frame = {1'b1, 3'h0, exec_phys, tt_q - (trc_cnt == 10'h000 ? tt_q
               : tt_base_q), 13'h0000};
    else
      frame = {1'b0, acc_code, bus_addr, bus_data, clips};
  end
  assign store = step & (~ctrl_q[`TBQ_C_TRQ] | trace_on_q)
                 & (cyc_exec | ctrl_q[`TBQ_C_TRCBUS]);
  assign clr_trace = wr_resume & reg_wdata[1];

  // First stored frame fixes the timetag origin
  always @(posedge mclk) begin
    if (rst)
      tt_base_q <= 11'h000;
    else if (store && trc_cnt == 10'h000)
      tt_base_q <= tt_q;
  end

  tbq_trace_store u_store (
    .mclk    (mclk),
    .rst     (rst),
    .clr     (clr_trace),
    .wr_en   (store),
    .wr_data (frame),
    .rd_idx  (trc_idx_q),
    .rd_data (rd_frame),
    .count   (trc_cnt),
    .full    (trc_full)
  );

  // Sticky events: exec, system, machine break, check, overflow
  assign irq_set = {store & trc_full, any_brk & ctrl_q[`TBQ_C_CHECK],
                    evm_break, sys_brk, exec_brk};
  assign irq = |(irq_stat_q & irq_en_q);

  // Register writes; hardware set beats software clear
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q       <= `TBQ_CTRL_RST;
      brk_en_q     <= 4'h0;
      brk_addr_q[0] <= 20'h00000;
      brk_addr_q[1] <= 20'h00000;
      brk_addr_q[2] <= 20'h00000;
      brk_addr_q[3] <= 20'h00000;
      arm_lo_q     <= 20'h00000;
      arm_hi_q     <= 20'h00000;
      sys_ctrl_q   <= 7'h00;
      sys_addr_q   <= 20'h00000;
      sys_data_q   <= 16'h0000;
      clip_q       <= 16'h0000;
      trq_start_q  <= 20'h00000;
      trq_end_q    <= 20'h00000;
      evm_prog_q[0] <= 28'h0000000;
      evm_prog_q[1] <= 28'h0000000;
      tick_q       <= `TBQ_TICK_RST;
      irq_stat_q   <= 5'h00;
      irq_en_q     <= 5'h00;
      trc_idx_q    <= 10'h000;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `TBQ_IRQ_CLR)
                     ? reg_wdata[4:0] : 5'h00)) | irq_set;
      if (reg_wr) begin
        case (reg_addr)
          `TBQ_CTRL:      ctrl_q      <= reg_wdata[6:0];
          `TBQ_BRK_EN:    brk_en_q    <= reg_wdata[3:0];
          8'h08:          brk_addr_q[0] <= reg_wdata[19:0];
          8'h0C:          brk_addr_q[1] <= reg_wdata[19:0];
          8'h10:          brk_addr_q[2] <= reg_wdata[19:0];
          8'h14:          brk_addr_q[3] <= reg_wdata[19:0];
          `TBQ_ARM_LO:    arm_lo_q    <= reg_wdata[19:0];
          `TBQ_ARM_HI:    arm_hi_q    <= reg_wdata[19:0];
          `TBQ_SYS_CTRL:  sys_ctrl_q  <= reg_wdata[6:0];
          `TBQ_SYS_ADDR:  sys_addr_q  <= reg_wdata[19:0];
          `TBQ_SYS_DATA:  sys_data_q  <= reg_wdata[15:0];
          `TBQ_CLIP:      clip_q      <= reg_wdata[15:0];
          `TBQ_TRQ_START: trq_start_q <= reg_wdata[19:0];
          `TBQ_TRQ_END:   trq_end_q   <= reg_wdata[19:0];
          `TBQ_EVM_BUS:   evm_prog_q[0] <= reg_wdata[27:0];
          `TBQ_EVM_EXEC:  evm_prog_q[1] <= reg_wdata[27:0];
          `TBQ_TICK:      tick_q      <= reg_wdata[15:0];
          `TBQ_IRQ_EN:    irq_en_q    <= reg_wdata[4:0];
          `TBQ_TRC_IDX:   trc_idx_q   <= reg_wdata[9:0];
          default:        ;
        endcase
      end
    end
  end

  // Frame reads need the store's registered port, so hold the address
  always @(posedge mclk) begin
    if (rst) begin
      rd_lo_q   <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_lo_q   <= reg_rd;
      rd_addr_q <= reg_addr;
    end
  end

  // Read data stands in the cycle after the strobe only
  always @* begin
    reg_rdata = 32'h00000000;
    if (rd_lo_q) begin
      case (rd_addr_q)
        `TBQ_CTRL:      reg_rdata = {25'h0000000, ctrl_q};
        `TBQ_BRK_EN:    reg_rdata = {28'h0000000, brk_en_q};
        8'h08:          reg_rdata = {12'h000, brk_addr_q[0]};
        8'h0C:          reg_rdata = {12'h000, brk_addr_q[1]};
        8'h10:          reg_rdata = {12'h000, brk_addr_q[2]};
        8'h14:          reg_rdata = {12'h000, brk_addr_q[3]};
        `TBQ_ARM_LO:    reg_rdata = {12'h000, arm_lo_q};
        `TBQ_ARM_HI:    reg_rdata = {12'h000, arm_hi_q};
        `TBQ_SYS_CTRL:  reg_rdata = {25'h0000000, sys_ctrl_q};
        `TBQ_SYS_ADDR:  reg_rdata = {12'h000, sys_addr_q};
        `TBQ_SYS_DATA:  reg_rdata = {16'h0000, sys_data_q};
        `TBQ_CLIP:      reg_rdata = {16'h0000, clip_q};
        `TBQ_TRQ_START: reg_rdata = {12'h000, trq_start_q};
        `TBQ_TRQ_END:   reg_rdata = {12'h000, trq_end_q};
        `TBQ_EVM_BUS:   reg_rdata = {4'h0, evm_prog_q[0]};
        `TBQ_EVM_EXEC:  reg_rdata = {4'h0, evm_prog_q[1]};
        `TBQ_TICK:      reg_rdata = {16'h0000, tick_q};
        `TBQ_STATUS:    reg_rdata = {5'h00, tt_q, evm_q[1], evm_q[0],
                                     3'h0, trc_full, check_pend_q,
                                     trace_on_q, window_q, halt_q};
        `TBQ_IRQ_STAT:  reg_rdata = {27'h0000000, irq_stat_q};
        `TBQ_IRQ_EN:    reg_rdata = {27'h0000000, irq_en_q};
        `TBQ_TRC_CNT:   reg_rdata = {22'h000000, trc_cnt};
        `TBQ_TRC_IDX:   reg_rdata = {22'h000000, trc_idx_q};
        `TBQ_TRC_LO:    reg_rdata = rd_frame[31:0];
        `TBQ_TRC_HI:    reg_rdata = {16'h0000, rd_frame[47:32]};
        default:        reg_rdata = 32'h00000000;
      endcase
    end
  end
endmodule

//--- src/tbq_defines.vh
`ifndef TBQ_DEFINES_VH
`define TBQ_DEFINES_VH
// Register byte offsets
`define TBQ_CTRL       8'h00
`define TBQ_BRK_EN     8'h04
`define TBQ_BRK_ADDR0  8'h08
`define TBQ_ARM_LO     8'h18
`define TBQ_ARM_HI     8'h1C
`define TBQ_SYS_CTRL   8'h20
`define TBQ_SYS_ADDR   8'h24
`define TBQ_SYS_DATA   8'h28
`define TBQ_CLIP       8'h2C
`define TBQ_TRQ_START  8'h30
`define TBQ_TRQ_END    8'h34
`define TBQ_EVM_BUS    8'h38
`define TBQ_EVM_EXEC   8'h3C
`define TBQ_TICK       8'h40
`define TBQ_STATUS     8'h44
`define TBQ_CHECK      8'h48
`define TBQ_RESUME     8'h4C
`define TBQ_IRQ_STAT   8'h50
`define TBQ_IRQ_CLR    8'h54
`define TBQ_IRQ_EN     8'h58
`define TBQ_TRC_CNT    8'h5C
`define TBQ_TRC_IDX    8'h60
`define TBQ_TRC_LO     8'h64
`define TBQ_TRC_HI     8'h68
// CTRL bits
`define TBQ_C_BRK      0
`define TBQ_C_SYS      1
`define TBQ_C_ARM      2
`define TBQ_C_TRQ      3
`define TBQ_C_EVM      4
`define TBQ_C_CHECK    5
`define TBQ_C_TRCBUS   6
`define TBQ_CTRL_RST   7'h40
// SYS_CTRL bits
`define TBQ_S_ADDR     0
`define TBQ_S_DATA     1
`define TBQ_S_CLIP     2
`define TBQ_S_SYSBRK   3
`define TBQ_S_COPROC   4
`define TBQ_S_RDONLY   5
`define TBQ_S_WRONLY   6
// Event machine conditions
`define TBQ_EC_ALWAYS  2'h0
`define TBQ_EC_EXEC    2'h1
`define TBQ_EC_SYS     2'h2
`define TBQ_EC_CROSS_MACHINE_LINK   2'h3
// Trace store
`define TBQ_DEPTH      1023
`define TBQ_FRAME_W    48
// Frame access codes
`define TBQ_AC_CODE_FETCH 3'h1
`define TBQ_AC_DATA_READ  3'h2
`define TBQ_AC_DATA_WRITE 3'h3
`define TBQ_AC_IO_READ    3'h4
`define TBQ_AC_IO_WRITE   3'h5
`define TBQ_AC_OTHER      3'h7
// Timetag
`define TBQ_CLK_NS     7'h08
`define TBQ_UNIT_NS    7'h64
`define TBQ_TICK_RST   16'h0002
`define TBQ_TT_W       11
`endif

//--- src/tbq_trace_store.v
`timescale 1ns/1ps
`include "tbq_defines.vh"
module tbq_trace_store (
  input  wire        mclk,
  input  wire        rst,
  input  wire        clr,
  input  wire        wr_en,
  input  wire [47:0] wr_data,
  input  wire [9:0]  rd_idx,
  output reg  [47:0] rd_data,
  output wire [9:0]  count,
  output wire        full
);
  localparam [9:0] LAST = 10'h3FE;
  localparam [9:0] DEPTH = 10'h3FF;
  reg [47:0] mem [0:`TBQ_DEPTH-1];
  reg [9:0]  wp_q;
  reg [9:0]  cnt_q;
  wire [10:0] sum;
  wire [9:0]  slot;
  assign count = cnt_q;
  assign full  = (cnt_q == DEPTH);
  // Ring in place of a shifter; index 0 always maps to the oldest frame
  assign sum  = {1'b0, (full ? wp_q : 10'h000)} + {1'b0, rd_idx};
  assign slot = (sum >= {1'b0, DEPTH}) ? (sum[9:0] - DEPTH) : sum[9:0];
  // Write side: once full, the newest overwrites the oldest
  always @(posedge mclk) begin
    if (rst || clr) begin
      wp_q  <= 10'h000;
      cnt_q <= 10'h000;
    end else if (wr_en) begin
      mem[wp_q] <= wr_data;
      wp_q      <= (wp_q == LAST) ? 10'h000 : wp_q + 10'h001;
      if (!full)
        cnt_q <= cnt_q + 10'h001;
    end
  end
  // Registered read port
  always @(posedge mclk) begin
    if (rst)
      rd_data <= 48'h000000000000;
    else
      rd_data <= (rd_idx < cnt_q) ? mem[slot] : 48'h000000000000;
  end
endmodule

//--- verification/tbq_cpu_model.sv
`timescale 1ns/1ps
// Target processor stand-in: at most one observed cycle per call
module tbq_cpu_model (
  input  wire logic        mclk,
  input  wire logic        halt,
  output logic             cyc_valid,
  output logic             cyc_exec,
  output logic [15:0]      exec_sel,
  output logic [15:0]      exec_off,
  output logic [19:0]      bus_addr,
  output logic [15:0]      bus_data,
  output logic             bus_write,
  output logic [1:0]       bus_space,
  output logic             coproc_cycle
);
  // Quiet bus at time zero
  initial begin
    {cyc_valid, cyc_exec, exec_sel, exec_off, bus_addr, bus_data,
     bus_write, bus_space, coproc_cycle} = '0;
  end
  // A halted processor issues nothing; released address and data lines show the inverse
  task automatic step(input logic x, input logic [15:0] s, o,
                      input logic [19:0] a, input logic [15:0] d,
                      input logic w, input logic [1:0] sp, input logic c);
    @(posedge mclk);
    if (!halt) begin
      {cyc_valid, cyc_exec, exec_sel, exec_off} <= {1'b1, x, s, o};
      {bus_addr, bus_data, bus_write} <= {a, d, w};
      {bus_space, coproc_cycle} <= {sp, c};
      @(posedge mclk);
      cyc_valid <= 1'b0;
      {bus_addr, bus_data} <= ~{a, d};
    end
  endtask
endmodule

//--- verification/tbq_checker.sv
`timescale 1ns/1ps
`include "tbq_defines.vh"
module tbq_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cyc_valid,
  input wire logic        halt,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Writes that may end a halt
  wire rel_wr = reg_wr && (reg_addr == `TBQ_RESUME ||
                           reg_addr == `TBQ_CHECK);
  sequence resume_wr;
    reg_wr && reg_addr == `TBQ_RESUME;
  endsequence
  sequence halt_rise;
    !halt ##1 halt;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  wo_read_a: assert property (
    reg_rd && reg_addr == `TBQ_RESUME |=> reg_rdata == 32'h0)
    else $error("write-only place read back nonzero");
  reset_clear_a: assert property (
    disable iff (1'b0) rst |=> !halt && !irq && reg_rdata == 32'h0)
    else $error("outputs not cleared by reset");
  halt_cause_a: assert property (halt_rise |-> $past(cyc_valid))
    else $error("halt rose without an observed cycle");
  halt_hold_a: assert property (halt && !rel_wr |=> halt)
    else $error("halt dropped without release write");
  resume_clear_a: assert property (halt ##0 resume_wr |=> !halt)
    else $error("resume write left halt high");
  irq_rise_a: assert property (
    $rose(irq) |-> $past(cyc_valid) || $past(reg_wr))
    else $error("irq rose without cause");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_wr) || $past(rst))
    else $error("irq fell without a write");
endmodule
bind tbq_qualifier tbq_checker i_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_valid(cyc_valid),
  .halt(halt), .irq(irq)
);

//--- verification/test_trace_break_qualifier.sv
`timescale 1ns/1ps
`include "tbq_defines.vh"
module test_trace_break_qualifier;
  logic        mclk, rst, reg_wr, reg_rd, sys_break_in, halt, irq;
  logic [7:0]  reg_addr, clips;
  logic [31:0] reg_wdata, reg_rdata, v, h, l, c1;
  logic        cyc_valid, cyc_exec, bus_write, coproc_cycle;
  logic [15:0] exec_sel, exec_off, bus_data;
  logic [19:0] bus_addr;
  logic [1:0]  bus_space;
  int          errors;
  int          comparisons;
  // Rows: address, mask, expected after reset
  localparam logic [71:0] ROWS [9] = '{
    {`TBQ_CTRL, 32'hFFFFFFFF, 32'h00000040},
    {`TBQ_BRK_EN, 32'hFFFFFFFF, 32'h00000000},
    {`TBQ_BRK_ADDR0, 32'hFFFFFFFF, 32'h00000000},
    {`TBQ_TICK, 32'hFFFFFFFF, 32'h00000002},
    {`TBQ_STATUS, 32'h0000FF1F, 32'h00001100},
    {`TBQ_IRQ_STAT, 32'hFFFFFFFF, 32'h00000000},
    {`TBQ_TRC_CNT, 32'hFFFFFFFF, 32'h00000000},
    {`TBQ_RESUME, 32'hFFFFFFFF, 32'h00000000},
    {8'h7C, 32'hFFFFFFFF, 32'h00000000}};
  tbq_qualifier i_dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cyc_valid(cyc_valid), .cyc_exec(cyc_exec), .exec_sel(exec_sel),
    .exec_off(exec_off), .bus_addr(bus_addr), .bus_data(bus_data),
    .bus_write(bus_write), .bus_space(bus_space),
    .coproc_cycle(coproc_cycle), .sys_break_in(sys_break_in),
    .clips(clips), .halt(halt), .irq(irq));
  tbq_cpu_model i_cpu (
    .mclk(mclk), .halt(halt), .cyc_valid(cyc_valid), .cyc_exec(cyc_exec),
    .exec_sel(exec_sel), .exec_off(exec_off), .bus_addr(bus_addr),
    .bus_data(bus_data), .bus_write(bus_write), .bus_space(bus_space),
    .coproc_cycle(coproc_cycle));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data are valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Sampled mid-cycle, while the answer still stands
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic fr(input logic [9:0] i, output logic [31:0] hi, lo);
    wr(`TBQ_TRC_IDX, {22'h0, i});
    rd(`TBQ_TRC_HI, hi);
    rd(`TBQ_TRC_LO, lo);
  endtask
  task automatic ex(input logic [19:0] p);
    i_cpu.step(1'b1, p[19:4], {12'h0, p[3:0]}, 20'h0, 16'h0, 1'b0,
               2'h0, 1'b0);
  endtask
  task automatic bs(input logic [19:0] a, input logic w, c);
    i_cpu.step(1'b0, 16'h0, 16'h0, a, 16'h1234, w, 2'h1, c);
  endtask
  // Settled halt check; a halted run is resumed for the next case
  task automatic hchk(input logic e);
    @(negedge mclk);
    chk(halt, e);
    if (halt === 1'b1) wr(`TBQ_RESUME, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, sys_break_in, reg_addr, reg_wdata, clips} = '0;
    errors = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({halt, irq}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      rd(ROWS[i][71:64], v);
      chk(v & ROWS[i][63:32], ROWS[i][31:0] & ROWS[i][63:32]);
    end
    // Two live break addresses, a third parked behind its enable bit
    wr(`TBQ_BRK_ADDR0, 32'h0002_4F);
    wr(8'h0C, 32'h00259);
    wr(8'h10, 32'h00300);
    wr(`TBQ_BRK_EN, 32'h3);
    wr(`TBQ_CTRL, 32'h41);
    ex(20'h0024E);
    hchk(1'b0);
    ex(20'h00300);
    hchk(1'b0);
    i_cpu.step(1'b1, 16'h0021, 16'h0049, 20'h0, 16'h0, 1'b0, 2'h0, 1'b0);
    @(negedge mclk);
    chk({halt, irq}, 32'h2);
    wr(`TBQ_IRQ_EN, 32'h1F);
    @(negedge mclk);
    chk(irq, 1'b1);
    rd(`TBQ_IRQ_STAT, v);
    chk(v, 32'h1);
    wr(`TBQ_IRQ_CLR, 32'h1);
    @(negedge mclk);
    chk(irq, 1'b0);
    hchk(1'b1);
    ex(20'h0024F);
    hchk(1'b1);
    // Fresh store: one execution frame, then one data write frame
    wr(`TBQ_CTRL, 32'h40);
    wr(`TBQ_RESUME, 32'h2);
    clips <= 8'h5A;
    i_cpu.step(1'b1, 16'h0021, 16'h003F, 20'h0, 16'h0, 1'b0, 2'h0, 1'b0);
    i_cpu.step(1'b0, 16'h0, 16'h0, 20'h00450, 16'h004B, 1'b1, 2'h1, 1'b0);
    rd(`TBQ_TRC_CNT, v);
    chk(v, 32'h2);
    fr(10'h0, h, l);
    chk(h & 32'h8FFF, 32'h8002);
    chk(l, 32'h4F000000);
    fr(10'h1, h, l);
    chk(h, 32'h3004);
    chk(l, 32'h50004B5A);
    // Qualified trace between start and end addresses
    wr(`TBQ_RESUME, 32'h2);
    wr(`TBQ_TRQ_START, 32'h00300);
    wr(`TBQ_TRQ_END, 32'h00310);
    wr(`TBQ_CTRL, 32'h48);
    ex(20'h002FF);
    rd(`TBQ_TRC_CNT, v);
    chk(v, 32'h0);
    for (int i = 0; i < 3; i++) ex(20'h00300 + 20'(4 * i));
    rd(`TBQ_TRC_CNT, c1);
    chk(c1 >= 32'h2, 1'b1);
    for (int i = 0; i < 3; i++) ex(20'h00310 + 20'(16 * i));
    rd(`TBQ_TRC_CNT, v);
    chk(v - c1 <= 32'h1, 1'b1);
    // Window opened by execution in range, closed by execution outside it; reads only
    wr(`TBQ_CTRL, 32'h44);
    wr(`TBQ_ARM_LO, 32'h00400);
    wr(`TBQ_ARM_HI, 32'h0040F);
    wr(`TBQ_SYS_ADDR, 32'h0044E);
    wr(`TBQ_SYS_CTRL, 32'h21);
    bs(20'h0044E, 1'b0, 1'b0);
    hchk(1'b0);
    ex(20'h00405);
    rd(`TBQ_STATUS, v);
    chk(v & 32'h2, 32'h2);
    bs(20'h0044E, 1'b1, 1'b0);
    hchk(1'b0);
    bs(20'h0044E, 1'b0, 1'b0);
    hchk(1'b1);
    ex(20'h00500);
    bs(20'h0044E, 1'b0, 1'b0);
    hchk(1'b0);
    // Direct system sources: clips, break line, coprocessor cycle
    wr(`TBQ_CLIP, 32'hFF5A);
    wr(`TBQ_CTRL, 32'h42);
    for (int i = 0; i < 3; i++) begin
      wr(`TBQ_SYS_CTRL, 32'h4 << i);
      clips <= 8'hA5;
      sys_break_in <= 1'b0;
      bs(20'h00600, 1'b0, 1'b0);
      hchk(1'b0);
      clips <= 8'h5A;
      sys_break_in <= (i == 1);
      bs(20'h00600, 1'b0, i == 2);
      hchk(1'b1);
    end
    sys_break_in <= 1'b0;
    // Exec machine parks in its top state; bus machine breaks on link
    wr(`TBQ_CTRL, 32'h50);
    wr(`TBQ_EVM_EXEC, 32'h03000019);
    wr(`TBQ_EVM_BUS, 32'h07);
    bs(20'h00700, 1'b0, 1'b0);
    hchk(1'b0);
    ex(20'h00405);
    rd(`TBQ_STATUS, v);
    chk(v & 32'hF000, 32'h8000);
    // Old sticky bits out of the way so only the machine break shows
    wr(`TBQ_IRQ_CLR, 32'h1F);
    bs(20'h00700, 1'b0, 1'b0);
    hchk(1'b1);
    rd(`TBQ_IRQ_STAT, v);
    chk(v & 32'h7, 32'h4);
    // Check procedure: false resumes, true stays halted
    wr(`TBQ_CTRL, 32'h61);
    ex(20'h0024F);
    rd(`TBQ_STATUS, v);
    chk(v & 32'h9, 32'h9);
    wr(`TBQ_CHECK, 32'h0);
    @(negedge mclk);
    chk(halt, 1'b0);
    ex(20'h0024F);
    wr(`TBQ_CHECK, 32'h1);
    hchk(1'b1);
    // Overflow: oldest frames drop, newest sits in the last slot
    wr(`TBQ_CTRL, 32'h40);
    wr(`TBQ_RESUME, 32'h2);
    for (int i = 1; i <= 1025; i++) ex(20'(i));
    rd(`TBQ_TRC_CNT, v);
    chk(v, 32'h3FF);
    rd(`TBQ_IRQ_STAT, v);
    chk(v & 32'h10, 32'h10);
    fr(10'h0, h, l);
    chk({h[11:0], l[31:24]}, 32'h00003);
    fr(10'h3FE, h, l);
    chk({h[11:0], l[31:24]}, 32'h00401);
    tally_and_finish();
  end
endmodule
